// *** sim/sscp_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// external spi master, mode 0, sck idle low between frames
module sscp_master_model #(
  parameter int HALF_NS = 200
) (
  output logic      spi_sck,     // link clock
  output logic      spi_cs_n,    // chip select, low
  output logic      spi_mosi,    // serial data out
  input  wire logic spi_miso,    // serial data in
  input  wire logic spi_miso_oe  // slave drives miso
);
  logic [7:0] tx_buf [0:23];
  logic [7:0] rx_buf [0:23];
  logic       last_miso;

  // idle levels at time zero
  initial begin
    spi_sck   = 1'b0;
    spi_cs_n  = 1'b1;
    spi_mosi  = 1'b1;
    last_miso = 1'b0;
  end

  // one frame of n bytes; undriven miso reads as inverse of last bit
  task automatic frame(input int n);
    int b;
    int i;
    #7;
    spi_cs_n = 1'b0;
    #(HALF_NS);
    for (b = 0; b < n; b++) begin
      for (i = 7; i >= 0; i--) begin
        spi_mosi = tx_buf[b][i];
        #(HALF_NS);
        spi_sck   = 1'b1;
        last_miso = spi_miso_oe ? spi_miso : ~last_miso;
        rx_buf[b][i] = last_miso;
        #(HALF_NS);
        spi_sck = 1'b0;
      end
    end
    #(HALF_NS);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #(2 * HALF_NS);
  endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic         mclk, rst, fw_ready_set, fw_tx_load, fw_rx_ready;
  logic [127:0] fw_tx_data;
  logic         spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [7:0]   fw_rx_data;
  logic         fw_rx_valid, fw_cmd_stb, fw_ready;
  logic [3:0]   fw_cmd, fw_count, last_cmd, last_cnt;
  int           n_fail, total_checks, n_stb, cycles;

  sscp_top u_sscp_top (.mclk(mclk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .fw_ready_set(fw_ready_set), .fw_tx_data(fw_tx_data), .fw_tx_load(fw_tx_load),
    .fw_rx_ready(fw_rx_ready), .fw_rx_data(fw_rx_data), .fw_rx_valid(fw_rx_valid),
    .fw_cmd(fw_cmd), .fw_count(fw_count), .fw_cmd_stb(fw_cmd_stb), .fw_ready(fw_ready));

  sscp_master_model u_sscp_master_model (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

  // core clock
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;

  // latch each decoded command and guard against hangs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (fw_cmd_stb === 1'b1) begin
      n_stb    <= n_stb + 1;
      last_cmd <= fw_cmd;
      last_cnt <= fw_count;
    end
    if (cycles == 60000) begin
      n_fail = n_fail + 1;
      $display("Error at %0t: run timed out", $time);
      results();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // op byte then n payload bytes counting up from base
  task automatic send(input logic [7:0] op, input int n, input logic [7:0] base);
    u_sscp_master_model.tx_buf[0] = op;
    for (int k = 0; k < n; k++) u_sscp_master_model.tx_buf[k + 1] = base + 8'(k);
    u_sscp_master_model.frame(n + 1);
    repeat (8) @(negedge mclk);
  endtask

  task automatic status(input logic [7:0] exp);
    send(sscp_pkg::OP_STATUS, 1, 8'h00);
    chk8(u_sscp_master_model.rx_buf[1], exp, "status reply");
  endtask

  task automatic set_ready();
    @(negedge mclk) fw_ready_set = 1'b1;
    @(negedge mclk) fw_ready_set = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  // firmware takes one payload byte
  task automatic pop(input logic [7:0] exp);
    int w;
    w = 0;
    while (fw_rx_valid !== 1'b1 && w < 200) begin
      @(negedge mclk);
      w++;
    end
    chk1(fw_rx_valid, 1'b1, "payload valid");
    chk8(fw_rx_data, exp, "payload byte");
    fw_rx_ready = 1'b1;
    @(negedge mclk) fw_rx_ready = 1'b0;
    repeat (2) @(negedge mclk);
  endtask

  task automatic t_reset();
    chk1(fw_ready, 1'b0, "ready after reset");
    chk1(fw_rx_valid, 1'b0, "valid after reset");
    chk1(fw_cmd_stb, 1'b0, "strobe after reset");
    status(sscp_pkg::STAT_BUSY);
    chk8({4'h0, last_cmd}, 8'(sscp_pkg::SSCP_CMD_STATUS), "status decode");
    $display("test reset done");
  endtask

  task automatic t_writes();
    logic [7:0] ops [4] = '{8'ha0, 8'ha7, 8'hb5, 8'hc2};
    logic [3:0] cmds [4];
    int n;
    cmds = '{sscp_pkg::SSCP_CMD_DREG_WR, sscp_pkg::SSCP_CMD_DREG_WR,
             sscp_pkg::SSCP_CMD_IREG_WR, sscp_pkg::SSCP_CMD_BURST_WR};
    for (int t = 0; t < 4; t++) begin
      n = int'(ops[t][3:0]) + 1;
      set_ready();
      status(sscp_pkg::STAT_READY);
      send(ops[t], n, 8'h30 + ops[t]);
      chk8({4'h0, last_cmd}, {4'h0, cmds[t]}, "write decode");
      chk8({4'h0, last_cnt}, {4'h0, ops[t][3:0]}, "write count");
      chk1(fw_ready, 1'b0, "ready cleared by write");
      set_ready();
      status(sscp_pkg::STAT_BUSY);
      for (int k = 0; k < n; k++) pop(8'h30 + ops[t] + 8'(k));
      status(sscp_pkg::STAT_READY);
    end
    $display("test writes done");
  endtask

  task automatic t_overflow();
    send(8'hbf, 16, 8'h50);
    status(sscp_pkg::STAT_BUSY);
    for (int k = 0; k < sscp_pkg::FIFO_DEPTH; k++) pop(8'h50 + 8'(k));
    repeat (20) @(negedge mclk);
    chk1(fw_rx_valid, 1'b0, "fifo empty after drain");
    set_ready();
    status(sscp_pkg::STAT_READY);
    $display("test overflow done");
  endtask

  task automatic t_reads();
    logic [7:0] ops [3] = '{8'h27, 8'h3f, 8'h40};
    int         plen [3] = '{1, 1, 3};
    logic [3:0] cmds [3];
    int n;
    cmds = '{sscp_pkg::SSCP_CMD_DREG_RD, sscp_pkg::SSCP_CMD_IREG_RD,
             sscp_pkg::SSCP_CMD_BURST_RD};
    for (int t = 0; t < 3; t++) begin
      n = int'(ops[t][3:0]) + 1;
      set_ready();
      send(ops[t], plen[t], 8'h60);
      chk8({4'h0, last_cmd}, {4'h0, cmds[t]}, "read decode");
      chk8({4'h0, last_cnt}, {4'h0, ops[t][3:0]}, "read count");
      for (int k = 0; k < plen[t]; k++) pop(8'h60 + 8'(k));
      status(sscp_pkg::STAT_BUSY);
      for (int k = 0; k < 16; k++) fw_tx_data[8*k +: 8] = ops[t] + 8'(k);
      @(negedge mclk) fw_tx_load = 1'b1;
      @(negedge mclk) fw_tx_load = 1'b0;
      set_ready();
      status(sscp_pkg::STAT_READY);
      send(sscp_pkg::OP_READ_DATA, n, 8'h00);
      chk8({4'h0, last_cmd}, 8'(sscp_pkg::SSCP_CMD_READ_DATA), "read data decode");
      for (int k = 0; k < n; k++)
        chk8(u_sscp_master_model.rx_buf[k + 1], ops[t] + 8'(k), "read lane");
    end
    $display("test reads done");
  endtask

  task automatic t_unknown();
    logic [7:0] ops [4] = '{8'h55, 8'ha8, 8'h28, 8'h01};
    int s0;
    set_ready();
    for (int t = 0; t < 4; t++) begin
      s0 = n_stb;
      send(ops[t], 2, 8'h70);
      chk1(1'(n_stb == s0), 1'b1, "no strobe on unknown op");
      chk1(fw_ready, 1'b1, "ready kept on unknown op");
      chk1(fw_rx_valid, 1'b0, "unknown payload dropped");
    end
    status(sscp_pkg::STAT_READY);
    $display("test unknown done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    fw_ready_set = 1'b0;
    fw_tx_load = 1'b0;
    fw_rx_ready = 1'b0;
    fw_tx_data = '0;
    n_fail = 0;
    total_checks = 0;
    n_stb = 0;
    cycles = 0;
    last_cmd = 4'h0;
    last_cnt = 4'h0;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_writes();
    t_overflow();
    t_reads();
    t_unknown();
    results();
  end
endmodule
`default_nettype wire

// *** verilog/sscp_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
// simple synchronous fifo, honest full/empty
module sscp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,      // clock
  input  wire logic             rst,      // async reset
  input  wire logic [WIDTH-1:0] in_data,  // write data
  input  wire logic             in_valid, // write request
  output logic                  in_ready, // not full
  output logic      [WIDTH-1:0] out_data, // head data
  output logic                  out_valid,// not empty
  input  wire logic             out_ready // head consumed
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  // handshakes
  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// *** verilog/sscp_pkg.sv ***
`default_nettype none
package sscp_pkg;
  // op-code patterns
  localparam logic [7:0] OP_STATUS       = 8'h00;
  localparam logic [7:0] OP_READ_DATA    = 8'h10;
  localparam logic [4:0] OP_DREG_WR_HI   = 5'h14;  // 1010_0xxx
  localparam logic [4:0] OP_DREG_RD_HI   = 5'h04;  // 0010_0xxx
  localparam logic [3:0] OP_IREG_WR_HI   = 4'hb;   // 1011_xxxx
  localparam logic [3:0] OP_IREG_RD_HI   = 4'h3;   // 0011_xxxx
  localparam logic [3:0] OP_BURST_RD_HI  = 4'h4;   // 0100_xxxx
  localparam logic [3:0] OP_BURST_WR_HI  = 4'hc;   // 1100_xxxx
  // status answers
  localparam logic [7:0] STAT_READY      = 8'h01;
  localparam logic [7:0] STAT_BUSY       = 8'h00;
  // buffer geometry
  localparam int         BUF_BYTES       = 16;
  localparam int         FIFO_DEPTH      = 8;
  localparam int         BYTE_W          = 8;
  localparam logic [7:0] BUF_RESET       = 8'h00;

  typedef enum logic [3:0] {
    SSCP_CMD_NONE, SSCP_CMD_STATUS, SSCP_CMD_READ_DATA, SSCP_CMD_DREG_WR,
    SSCP_CMD_DREG_RD, SSCP_CMD_IREG_WR, SSCP_CMD_IREG_RD, SSCP_CMD_BURST_RD,
    SSCP_CMD_BURST_WR
  } sscp_cmd_e;
endpackage
`default_nettype wire

// *** verilog/sscp_shift.sv ***
`timescale 1ns/100ps
`default_nettype none
// spi mode 0 byte shifter, msb first, sampled on mclk
module sscp_shift (
  input  wire logic       mclk,      // core clock
  input  wire logic       rst,       // async reset
  input  wire logic       sck_rise,  // sampled sck rising edge
  input  wire logic       sck_fall,  // sampled sck falling edge
  input  wire logic       frame,     // chip select active
  input  wire logic       mosi_s,    // synchronised mosi
  input  wire logic [7:0] tx_byte,   // byte to send next
  output logic            tx_take,   // pulse: tx_byte loaded
  output logic      [7:0] rx_byte,   // last received byte
  output logic            rx_done,   // pulse: byte complete
  output logic            miso_bit   // current output bit
);
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] bit_cnt_reg;

  // receive msb first, count bits
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_sh_reg   <= 8'h00;
      bit_cnt_reg <= 3'h0;
      rx_byte     <= 8'h00;
      rx_done     <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (!frame) begin
        bit_cnt_reg <= 3'h0;
      end else if (sck_rise) begin
        rx_sh_reg   <= {rx_sh_reg[6:0], mosi_s};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          rx_byte <= {rx_sh_reg[6:0], mosi_s};
          rx_done <= 1'b1;
        end
      end
    end
  end

  // transmit msb first, reload at byte boundary
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_sh_reg <= 8'h00;
      tx_take   <= 1'b0;
    end else begin
      tx_take <= 1'b0;
      if (!frame) begin
        tx_sh_reg <= 8'h00;
      end else if (sck_fall) begin
        if (bit_cnt_reg == 3'h0) begin
          tx_sh_reg <= tx_byte;
          tx_take   <= 1'b1;
        end else begin
          tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
        end
      end
    end
  end

  assign miso_bit = tx_sh_reg[7];
endmodule
`default_nettype wire

// *** verilog/sscp_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module sscp_top (
  input  wire logic         mclk,          // 20 mhz core clock
  input  wire logic         rst,           // async reset, high
  input  wire logic         spi_sck,       // link clock pin
  input  wire logic         spi_cs_n,      // chip select pin, low
  input  wire logic         spi_mosi,      // serial data in
  output logic              spi_miso,      // serial data out
  output logic              spi_miso_oe,   // miso drive enable
  input  wire logic         fw_ready_set,  // firmware sets ready
  input  wire logic [127:0] fw_tx_data,    // firmware read data
  input  wire logic         fw_tx_load,    // load read data to buffer
  input  wire logic         fw_rx_ready,   // firmware takes a byte
  output logic        [7:0] fw_rx_data,    // byte to firmware
  output logic              fw_rx_valid,   // byte available
  output logic        [3:0] fw_cmd,        // decoded command
  output logic        [3:0] fw_count,      // byte count minus one
  output logic              fw_cmd_stb,    // pulse: new command
  output logic              fw_ready       // ready flag state
);
  // input synchronisers
  logic [1:0] sck_sync_reg;
  logic [1:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;
  logic       sck_prev_reg;
  logic       sck_rise;
  logic       sck_fall;
  logic       frame;
  logic [7:0] rx_byte;
  logic       rx_done;
  logic       tx_take;
  logic       miso_bit;
  logic [7:0] tx_byte;
  logic       first_reg;
  sscp_pkg::sscp_cmd_e cmd_reg;
  sscp_pkg::sscp_cmd_e cmd_next;
  logic [3:0] cnt_next;
  logic [7:0] buf_mem [sscp_pkg::BUF_BYTES];
  logic [3:0] tx_idx_reg;
  logic [7:0] fifo_dout;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic       fifo_push;

  // two-flop sync of every spi input pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_sync_reg  <= 2'h0;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sck_prev_reg  <= 1'b0;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[0], spi_sck};
      cs_sync_reg   <= {cs_sync_reg[0], spi_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
      sck_prev_reg  <= sck_sync_reg[1];
    end
  end

  // edge detection on synchronised clock
  assign sck_rise = sck_sync_reg[1] && !sck_prev_reg;
  assign sck_fall = !sck_sync_reg[1] && sck_prev_reg;
  assign frame    = !cs_sync_reg[1];

  sscp_shift u_shift (
    .mclk     (mclk),
    .rst      (rst),
    .sck_rise (sck_rise),
    .sck_fall (sck_fall),
    .frame    (frame),
    .mosi_s   (mosi_sync_reg[1]),
    .tx_byte  (tx_byte),
    .tx_take  (tx_take),
    .rx_byte  (rx_byte),
    .rx_done  (rx_done),
    .miso_bit (miso_bit)
  );

  // op-code classifier
  function automatic sscp_pkg::sscp_cmd_e sscp_decode(input logic [7:0] op);
    sscp_pkg::sscp_cmd_e c;
    c = sscp_pkg::SSCP_CMD_NONE;
    if (op == sscp_pkg::OP_STATUS) begin
      c = sscp_pkg::SSCP_CMD_STATUS;
    end else if (op == sscp_pkg::OP_READ_DATA) begin
      c = sscp_pkg::SSCP_CMD_READ_DATA;
    end else if (op[7:3] == sscp_pkg::OP_DREG_WR_HI) begin
      c = sscp_pkg::SSCP_CMD_DREG_WR;
    end else if (op[7:3] == sscp_pkg::OP_DREG_RD_HI) begin
      c = sscp_pkg::SSCP_CMD_DREG_RD;
    end else if (op[7:4] == sscp_pkg::OP_IREG_WR_HI) begin
      c = sscp_pkg::SSCP_CMD_IREG_WR;
    end else if (op[7:4] == sscp_pkg::OP_IREG_RD_HI) begin
      c = sscp_pkg::SSCP_CMD_IREG_RD;
    end else if (op[7:4] == sscp_pkg::OP_BURST_RD_HI) begin
      c = sscp_pkg::SSCP_CMD_BURST_RD;
    end else if (op[7:4] == sscp_pkg::OP_BURST_WR_HI) begin
      c = sscp_pkg::SSCP_CMD_BURST_WR;
    end
    return c;
  endfunction

  always_comb begin
    cmd_next = sscp_decode(rx_byte);
    cnt_next = rx_byte[3:0];
    // direct access uses three count bits
    if (cmd_next == sscp_pkg::SSCP_CMD_DREG_WR || cmd_next == sscp_pkg::SSCP_CMD_DREG_RD) begin
      cnt_next = {1'b0, rx_byte[2:0]};
    end
  end

  // frame phase and command latch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      first_reg  <= 1'b1;
      cmd_reg    <= sscp_pkg::SSCP_CMD_NONE;
      fw_cmd     <= 4'h0;
      fw_count   <= 4'h0;
      fw_cmd_stb <= 1'b0;
    end else begin
      fw_cmd_stb <= 1'b0;
      if (!frame) begin
        first_reg <= 1'b1;
      end else if (rx_done && first_reg) begin
        first_reg <= 1'b0;
        cmd_reg   <= cmd_next;
        if (cmd_next != sscp_pkg::SSCP_CMD_NONE) begin
          fw_cmd     <= cmd_next;
          fw_count   <= cnt_next;
          fw_cmd_stb <= 1'b1;
        end
      end
    end
  end

  // payload bytes of data commands go to firmware
  assign fifo_push = rx_done && !first_reg && frame &&
                     (cmd_reg == sscp_pkg::SSCP_CMD_DREG_WR ||
                      cmd_reg == sscp_pkg::SSCP_CMD_DREG_RD ||
                      cmd_reg == sscp_pkg::SSCP_CMD_IREG_WR ||
                      cmd_reg == sscp_pkg::SSCP_CMD_IREG_RD ||
                      cmd_reg == sscp_pkg::SSCP_CMD_BURST_RD ||
                      cmd_reg == sscp_pkg::SSCP_CMD_BURST_WR);

  // index/data pairs handled by firmware via fifo
  sscp_fifo #(
    .WIDTH (sscp_pkg::BYTE_W),
    .DEPTH (sscp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (mclk),
    .rst       (rst),
    .in_data   (rx_byte),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_dout),
    .out_valid (fifo_out_valid),
    .out_ready (fw_rx_ready && fw_rx_valid)
  );

  // registered view of fifo head for firmware
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fw_rx_data  <= 8'h00;
      fw_rx_valid <= 1'b0;
    end else begin
      fw_rx_data  <= fifo_dout;
      fw_rx_valid <= fifo_out_valid && !(fw_rx_ready && fw_rx_valid);
    end
  end

  // ready flag set by firmware, cleared by a new register or burst command, not by status or read-data
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fw_ready <= 1'b0;
    end else if (fw_ready_set) begin
      fw_ready <= 1'b1;
    end else if (rx_done && first_reg && frame &&
                 cmd_next != sscp_pkg::SSCP_CMD_NONE &&
                 cmd_next != sscp_pkg::SSCP_CMD_STATUS &&
                 cmd_next != sscp_pkg::SSCP_CMD_READ_DATA) begin
      fw_ready <= 1'b0;
    end
  end

  // buffer loaded lane order, byte 0 lowest
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < sscp_pkg::BUF_BYTES; i++) begin
        buf_mem[i] <= sscp_pkg::BUF_RESET;
      end
    end else if (fw_tx_load) begin
      for (int i = 0; i < sscp_pkg::BUF_BYTES; i++) begin
        buf_mem[i] <= fw_tx_data[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_idx_reg <= 4'h0;
    end else if (!frame) begin
      tx_idx_reg <= 4'h0;
    end else if (tx_take && !first_reg && cmd_reg == sscp_pkg::SSCP_CMD_READ_DATA) begin
      tx_idx_reg <= tx_idx_reg + 4'h1;
    end
  end

  // status answer, busy while fifo holds bytes
  // read flow ready when firmware flagged buffer
  always_comb begin
    tx_byte = sscp_pkg::STAT_BUSY;
    if (!first_reg && cmd_reg == sscp_pkg::SSCP_CMD_STATUS) begin
      tx_byte = (fw_ready && !fifo_out_valid) ? sscp_pkg::STAT_READY : sscp_pkg::STAT_BUSY;
    end else if (!first_reg && cmd_reg == sscp_pkg::SSCP_CMD_READ_DATA) begin
      tx_byte = buf_mem[tx_idx_reg];
    end
  end

  // registered miso and enable
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso    <= miso_bit;
      spi_miso_oe <= frame;
    end
  end

  property p_ready_set;
    @(posedge mclk) disable iff (rst) fw_ready_set |=> fw_ready;
  endproperty
  a_ready_set: assert property (p_ready_set) else $error("ready flag not set");

  // unknown op leaves ready flag alone
  property p_unknown_keeps;
    @(posedge mclk) disable iff (rst)
      (rx_done && first_reg && frame && cmd_next == sscp_pkg::SSCP_CMD_NONE && !fw_ready_set)
      |=> $stable(fw_ready) && !fw_cmd_stb;
  endproperty
  a_unknown_keeps: assert property (p_unknown_keeps) else $error("unknown op changed state");

  // direct write count is three bits
  property p_dreg_cnt;
    @(posedge mclk) disable iff (rst)
      (fw_cmd_stb && fw_cmd == sscp_pkg::SSCP_CMD_DREG_WR) |-> fw_count[3] == 1'b0;
  endproperty
  a_dreg_cnt: assert property (p_dreg_cnt) else $error("direct write count too large");

  // busy answered while fifo holds data
  property p_busy;
    @(posedge mclk) disable iff (rst)
      (!first_reg && cmd_reg == sscp_pkg::SSCP_CMD_STATUS && fifo_out_valid) |-> tx_byte == 8'h00;
  endproperty
  a_busy: assert property (p_busy) else $error("status ready while fifo busy");

  // command strobe follows the read-data op byte
  property p_cmd_stb;
    @(posedge mclk) disable iff (rst)
      (rx_done && first_reg && frame && rx_byte == 8'h10) |=> fw_cmd_stb && fw_cmd == sscp_pkg::SSCP_CMD_READ_DATA;
  endproperty
  a_cmd_stb: assert property (p_cmd_stb) else $error("read-data op not decoded");

  property p_op_not_fifo;
    @(posedge mclk) disable iff (rst) (rx_done && first_reg) |-> !fifo_push;
  endproperty
  a_op_not_fifo: assert property (p_op_not_fifo) else $error("op byte pushed");

  // payload byte with room lands in fifo
  property p_push_lands;
    @(posedge mclk) disable iff (rst) (fifo_push && fifo_in_ready) |=> fifo_out_valid;
  endproperty
  a_push_lands: assert property (p_push_lands) else $error("payload byte lost with room");

  // read index advances per sent byte
  property p_tx_idx;
    @(posedge mclk) disable iff (rst)
      (frame && tx_take && !first_reg && cmd_reg == sscp_pkg::SSCP_CMD_READ_DATA)
      |=> tx_idx_reg == $past(tx_idx_reg) + 4'h1;
  endproperty
  a_tx_idx: assert property (p_tx_idx) else $error("read index stuck");

  property p_oe;
    @(posedge mclk) disable iff (rst) !frame |=> !spi_miso_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("miso driven outside frame");
endmodule
`default_nettype wire
